// >>> lane_ctrl_regs.svh
`ifndef LANE_CTRL_REGS_SVH
`define LANE_CTRL_REGS_SVH

// ==========================================================
// Register indices (management register address)
`define ADDR_ENABLE_RATE   16'h0007
`define ADDR_POL_EQ        16'h0008

// ==========================================================
// Reset values
`define RST_ENABLE_RATE    16'hDC04
`define RST_POL_EQ         16'h000D

// ==========================================================
// Field positions, enable/rate/emphasis register
`define POS_SWING_LO       12
`define POS_SWING_HI       14
`define POS_TX_EN          10
`define POS_TX_RATE_LO     8
`define POS_TX_RATE_HI     9
`define POS_DEEMPH_LO      4
`define POS_DEEMPH_HI      7
`define POS_RX_EN          2
`define POS_RX_RATE_LO     0
`define POS_RX_RATE_HI     1

// ==========================================================
// Field positions, polarity/equalization register
`define POS_RX_INV         15
`define POS_TX_INV         14
`define POS_EQ_LO          8
`define POS_EQ_HI          11

// ==========================================================
// Lane masks per lane-count mode
`define LANES_FOUR         4'hF
`define LANES_TWO          4'h3
`define LANES_ONE          4'h1

`endif

// >>> lane_ctrl_pkg.sv
package lane_ctrl_pkg;

  // Lane-count mode of the channel
  typedef enum logic [1:0]
  {
    MODE_FOUR_LANE,
    MODE_TWO_LANE_10G,
    MODE_ONE_LANE_10G,
    MODE_KX_1G
  } lane_mode_t;

  // Lane rate encoding
  typedef enum logic [1:0]
  {
    RATE_FULL    = 2'h0,
    RATE_HALF    = 2'h1,
    RATE_QUARTER = 2'h2,
    RATE_RSVD    = 2'h3
  } lane_rate_t;

endpackage

// >>> lane_ctrl_word.sv
`timescale 1ns/1ns
`include "lane_ctrl_regs.svh"

// Single 16-bit read-write register word with its own reset value
module lane_ctrl_word #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        wrEn,
  input  wire logic [15:0] wrData,
  output logic      [15:0] value
);

  logic [15:0] word_d;
  logic [15:0] word_q;

  // ==========================================================
  // Next value: whole word stored, reserved bits included
  always_comb
  begin
    word_d = word_q;
    if (wrEn)
    begin
      word_d = wrData;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      word_q <= RESET_VALUE;
    end
    else if (ce)
    begin
      word_q <= word_d;
    end
  end

  assign value = word_q;

endmodule

// >>> low_speed_serdes_lane_control_regs.sv
`timescale 1ns/1ns
`include "lane_ctrl_regs.svh"

// How it works
// RULE1: TX lane enable bit, reset 1; forced off by power-down pin low or global power-down.
// RULE2: TX lanes 3,2 off in two-lane 10G; lanes 3,2,1 off in one-lane/KX.
// RULE3: RX lane enable bit, reset 1; forced off by power-down pin low or global power-down.
// RULE4: RX lanes 3,2 off in two-lane 10G; lanes 3,2,1 off in one-lane/KX.
// RULE5: TX rate field: 00 full (reset), 01 half, 10 quarter, 11 reserved.
// RULE6: RX rate field: same encoding, reset full rate.
// RULE7: Four-bit de-emphasis code, reset 0000, sixteen equal reduction steps.
// RULE8: RX polarity bit swaps each lane output pair when set.
// RULE9: TX polarity bit treats each lane input pair as swapped when set.
// RULE10: Four-bit equalizer code, reset 0000: max gain, adaptive, reserved, zero steps.
// RULE11: Three-bit swing code selects eight increasing output amplitudes.
// RULE12: Reserved fields and reserved rate codes store and read back without effect.
module low_speed_serdes_lane_control_regs #(
  parameter int LANES = 4
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     ce,
  input  wire logic [15:0]              regAddr,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  input  wire logic [15:0]              regWrData,
  output logic      [15:0]              regRdData,
  output logic                          regRdValid,
  input  wire logic                     channel_powerdown_pin_n,
  input  wire logic                     globalPowerdown,
  input  wire lane_ctrl_pkg::lane_mode_t laneMode,
  input  wire logic [LANES-1:0]         lane_in_pos,
  input  wire logic [LANES-1:0]         lane_in_neg,
  input  wire logic [LANES-1:0]         rxLaneData,
  output logic      [LANES-1:0]         txLaneEnable,
  output logic      [LANES-1:0]         rxLaneEnable,
  output lane_ctrl_pkg::lane_rate_t     tx_lane_rate_sel,
  output lane_ctrl_pkg::lane_rate_t     rx_lane_rate_sel,
  output logic      [3:0]               output_deemphasis_sel,
  output logic      [3:0]               input_equalizer_sel,
  output logic      [2:0]               output_swing_sel,
  output logic      [LANES-1:0]         txLaneData,
  output logic      [LANES-1:0]         lane_out_pos,
  output logic      [LANES-1:0]         lane_out_neg
);

  logic [15:0] enableRateWord;
  logic [15:0] polEqWord;
  logic        wrEnableRate;
  logic        wrPolEq;

  // ==========================================================
  // Register map
  // 0x0007: swing code, tx enable and rate, de-emphasis, rx enable and rate
  // 0x0008: rx and tx pair polarity, equalizer code
  // Every other bit of both words is plain read-write storage
  // A write reaches its word at its edge and the outputs one enabled edge later

  // ==========================================================
  // Register words
  // Both words live in the small word module so reset values stay local
  // Decode: a write strobe hits at most one word
  // With ce low every flop below holds, words included
  assign wrEnableRate = regWrite && (regAddr == `ADDR_ENABLE_RATE);
  assign wrPolEq      = regWrite && (regAddr == `ADDR_POL_EQ);

  // Enable, rate, emphasis and swing word
  // RULE12: reserved bits kept
  lane_ctrl_word #(
    .RESET_VALUE (`RST_ENABLE_RATE)
  ) enableRateReg (
    .clk    (clk),
    .nrst   (nrst),
    .ce     (ce),
    .wrEn   (wrEnableRate),
    .wrData (regWrData),
    .value  (enableRateWord)
  );

  // Polarity and equalizer word
  lane_ctrl_word #(
    .RESET_VALUE (`RST_POL_EQ)
  ) polEqReg (
    .clk    (clk),
    .nrst   (nrst),
    .ce     (ce),
    .wrEn   (wrPolEq),
    .wrData (regWrData),
    .value  (polEqWord)
  );

  // ==========================================================
  // Read port
  // Reads answer one edge after the strobe; the data holds until the next read, the valid flag does not
  logic [15:0] regRdData_d;
  logic [15:0] regRdData_q;
  logic        regRdValid_d;
  logic        regRdValid_q;

  // Unmapped addresses read as zero
  always_comb
  begin
    regRdValid_d = regRead;
    // Hold the last answer between reads
    regRdData_d  = regRdData_q;
    if (regRead)
    begin
      case (regAddr)
        `ADDR_ENABLE_RATE: regRdData_d = enableRateWord;
        `ADDR_POL_EQ:      regRdData_d = polEqWord;
        default:           regRdData_d = 16'h0000;
      endcase
    end
  end

  // Answer registers, so both read outputs leave on a flop
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regRdData_q  <= 16'h0000;
      regRdValid_q <= 1'b0;
    end
    else if (ce)
    begin
      regRdData_q  <= regRdData_d;
      regRdValid_q <= regRdValid_d;
    end
  end

  // Read outputs straight from the flops
  assign regRdData  = regRdData_q;
  assign regRdValid = regRdValid_q;

  // ==========================================================
  // Lane enables
  // Power gate and mode mask together decide each lane
  logic [LANES-1:0] modeMask;
  logic             powerOk;
  logic [LANES-1:0] txEn_d;
  logic [LANES-1:0] txEn_q;
  logic [LANES-1:0] rxEn_d;
  logic [LANES-1:0] rxEn_q;

  // Mode mask computed per lane; lanes beyond the mask width stay off except in four-lane mode, which sets every bit
  always_comb
  begin
    modeMask = '1;
    case (laneMode)
      // RULE2: two-lane drops 3,2
      // RULE4: same on receive
      lane_ctrl_pkg::MODE_TWO_LANE_10G: modeMask = LANES'(`LANES_TWO);
      lane_ctrl_pkg::MODE_ONE_LANE_10G: modeMask = LANES'(`LANES_ONE);
      // KX shares the single-lane mask
      lane_ctrl_pkg::MODE_KX_1G:        modeMask = LANES'(`LANES_ONE);
      // Four-lane mode keeps every lane
      default:                          modeMask = '1;
    endcase
  end

  // Power-down pin is active low; global bit wins regardless of enable
  assign powerOk = channel_powerdown_pin_n && !globalPowerdown;

  always_comb
  begin
    // RULE1: tx enable gating
    txEn_d = (powerOk && enableRateWord[`POS_TX_EN]) ? modeMask : '0;
    // RULE3: rx enable gating
    rxEn_d = (powerOk && enableRateWord[`POS_RX_EN]) ? modeMask : '0;
  end

  // Enables reset off; lanes come up at the first enabled edge after reset
  // so the analog side never sees a lane on while the words are resetting
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txEn_q <= '0;
      rxEn_q <= '0;
    end
    else if (ce)
    begin
      txEn_q <= txEn_d;
      rxEn_q <= rxEn_d;
    end
  end

  // Enable outputs straight from the flops
  assign txLaneEnable = txEn_q;
  assign rxLaneEnable = rxEn_q;

  // ==========================================================
  // Analog setting codes, registered for clean outputs
  lane_ctrl_pkg::lane_rate_t txRate_d;
  lane_ctrl_pkg::lane_rate_t txRate_q;
  lane_ctrl_pkg::lane_rate_t rxRate_d;
  lane_ctrl_pkg::lane_rate_t rxRate_q;
  logic [3:0]                deemph_d;
  logic [3:0]                deemph_q;
  logic [3:0]                eq_d;
  logic [3:0]                eq_q;
  logic [2:0]                swing_d;
  logic [2:0]                swing_q;

  // Codes pass through untouched; reserved codes are the analog side's concern
  always_comb
  begin
    // RULE5: tx rate code
    txRate_d = lane_ctrl_pkg::lane_rate_t'(enableRateWord[`POS_TX_RATE_HI:`POS_TX_RATE_LO]);
    // RULE6: rx rate code
    rxRate_d = lane_ctrl_pkg::lane_rate_t'(enableRateWord[`POS_RX_RATE_HI:`POS_RX_RATE_LO]);
    // RULE7: de-emphasis step
    deemph_d = enableRateWord[`POS_DEEMPH_HI:`POS_DEEMPH_LO];
    // RULE10: equalizer code
    eq_d     = polEqWord[`POS_EQ_HI:`POS_EQ_LO];
    // RULE11: swing code
    swing_d  = enableRateWord[`POS_SWING_HI:`POS_SWING_LO];
  end

  // Swing resets to code 5, the others to zero, matching the word reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txRate_q <= lane_ctrl_pkg::RATE_FULL;
      rxRate_q <= lane_ctrl_pkg::RATE_FULL;
      deemph_q <= 4'h0;
      eq_q     <= 4'h0;
      swing_q  <= 3'h5;
    end
    else if (ce)
    begin
      txRate_q <= txRate_d;
      rxRate_q <= rxRate_d;
      deemph_q <= deemph_d;
      eq_q     <= eq_d;
      swing_q  <= swing_d;
    end
  end

  // Code outputs straight from the flops
  assign tx_lane_rate_sel      = txRate_q;
  assign rx_lane_rate_sel      = rxRate_q;
  assign output_deemphasis_sel = deemph_q;
  assign input_equalizer_sel   = eq_q;
  assign output_swing_sel      = swing_q;

  // ==========================================================
  // Per-lane polarity handling
  // Limitation: pairs are modelled as logic levels; the analog pair lives outside
  // Swap stage inputs and registered lane outputs
  logic [LANES-1:0] txData_d;
  logic [LANES-1:0] txData_q;
  logic [LANES-1:0] outPos_d;
  logic [LANES-1:0] outPos_q;
  logic [LANES-1:0] outNeg_d;
  logic [LANES-1:0] outNeg_q;

  // One swap stage per lane; tx picks a wire, rx drives a pair
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : gLane
      always_comb
      begin
        // RULE9: input pair swap
        txData_d[g] = polEqWord[`POS_TX_INV] ? lane_in_neg[g] : lane_in_pos[g];
        // Each output pair carries the data and its inverse
        // RULE8: output pair swap
        outPos_d[g] = polEqWord[`POS_RX_INV] ? !rxLaneData[g] : rxLaneData[g];
        outNeg_d[g] = polEqWord[`POS_RX_INV] ? rxLaneData[g] : !rxLaneData[g];
      end
    end
  endgenerate

  // Disabled lanes hold a quiet idle pattern rather than stale data
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txData_q <= '0;
      outPos_q <= '0;
      outNeg_q <= '0;
    end
    else if (ce)
    begin
      txData_q <= txData_d & txEn_d;
      outPos_q <= outPos_d & rxEn_d;
      outNeg_q <= outNeg_d & rxEn_d;
    end
  end

  // Lane outputs straight from the flops
  assign txLaneData   = txData_q;
  assign lane_out_pos = outPos_q;
  assign lane_out_neg = outNeg_q;

  // ==========================================================
  // Limitations
  // Only the two lane-control words live here; other words decode elsewhere
  // The global power-down bit arrives as a pin from the word that holds it
  // Rate, swing, emphasis and equalizer settings leave as codes, not levels

endmodule

// >>> lane_ctrl_monitor.sv
`timescale 1ns/1ns
`include "lane_ctrl_regs.svh"
// ==========
// Port checker for the lane control registers
module lane_ctrl_monitor #(
  parameter int LANES = 4
) (
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire logic                      ce,
  input wire logic [15:0]               regAddr,
  input wire logic                      regWrite,
  input wire logic                      regRead,
  input wire logic [15:0]               regWrData,
  input wire logic [15:0]               regRdData,
  input wire logic                      regRdValid,
  input wire logic                      channel_powerdown_pin_n,
  input wire logic                      globalPowerdown,
  input wire lane_ctrl_pkg::lane_mode_t laneMode,
  input wire logic [LANES-1:0]          lane_in_pos,
  input wire logic [LANES-1:0]          lane_in_neg,
  input wire logic [LANES-1:0]          rxLaneData,
  input wire logic [LANES-1:0]          txLaneEnable,
  input wire logic [LANES-1:0]          rxLaneEnable,
  input wire lane_ctrl_pkg::lane_rate_t tx_lane_rate_sel,
  input wire lane_ctrl_pkg::lane_rate_t rx_lane_rate_sel,
  input wire logic [3:0]                output_deemphasis_sel,
  input wire logic [3:0]                input_equalizer_sel,
  input wire logic [2:0]                output_swing_sel,
  input wire logic [LANES-1:0]          txLaneData,
  input wire logic [LANES-1:0]          lane_out_pos,
  input wire logic [LANES-1:0]          lane_out_neg
);
  logic [15:0] w7_q, w7_d, w8_q, w8_d, p7_q, p7_d, p8_q, p8_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Shadow words, delayed once more to match the output lag
  always_comb
  begin
    w7_d = (ce && regWrite && regAddr == `ADDR_ENABLE_RATE) ? regWrData : w7_q;
    w8_d = (ce && regWrite && regAddr == `ADDR_POL_EQ) ? regWrData : w8_q;
    p7_d = ce ? w7_q : p7_q;
    p8_d = ce ? w8_q : p8_q;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      w7_q <= `RST_ENABLE_RATE;
      w8_q <= `RST_POL_EQ;
      p7_q <= `RST_ENABLE_RATE;
      p8_q <= `RST_POL_EQ;
    end
    else
    begin
      w7_q <= w7_d;
      w8_q <= w8_d;
      p7_q <= p7_d;
      p8_q <= p8_d;
    end
  end

  // ==========
  // Write then settle: a ce edge must follow the taken write
  sequence wr7Seq;
    ce && regWrite && regAddr == `ADDR_ENABLE_RATE ##1 ce;
  endsequence
  sequence wr8Seq;
    ce && regWrite && regAddr == `ADDR_POL_EQ ##1 ce;
  endsequence

  pwr_tx_off_a: assert property (ce && (!channel_powerdown_pin_n || globalPowerdown) |=> txLaneEnable == '0)
    else $error("tx lanes on during power-down");
  pwr_rx_off_a: assert property (ce && (!channel_powerdown_pin_n || globalPowerdown) |=> rxLaneEnable == '0)
    else $error("rx lanes on during power-down");
  two_lane_tx_a: assert property (ce && laneMode == lane_ctrl_pkg::MODE_TWO_LANE_10G |=> txLaneEnable[3:2] == 2'h0)
    else $error("tx upper lanes on in two-lane mode");
  one_lane_rx_a: assert property (ce && laneMode inside {lane_ctrl_pkg::MODE_ONE_LANE_10G, lane_ctrl_pkg::MODE_KX_1G}
    |=> rxLaneEnable[3:1] == 3'h0) else $error("rx upper lanes on in one-lane mode");
  unmapped_rd_a: assert property (ce && regRead && !(regAddr inside {16'h0007, 16'h0008})
    |=> regRdValid && regRdData == 16'h0000) else $error("unmapped read not zero");
  tx_gate_a: assert property ((txLaneData & ~txLaneEnable) == '0)
    else $error("tx data passes on a disabled lane");
  pair_cmpl_a: assert property ((lane_out_pos ^ lane_out_neg) == rxLaneEnable)
    else $error("output pair not complementary");
  word7_out_a: assert property (wr7Seq |=> {output_swing_sel, tx_lane_rate_sel, output_deemphasis_sel, rx_lane_rate_sel}
    == {p7_q[14:12], p7_q[9:8], p7_q[7:4], p7_q[1:0]}) else $error("control fields do not follow write");
  word8_out_a: assert property (wr8Seq |=> input_equalizer_sel == p8_q[11:8])
    else $error("equalizer code does not follow write");
  tx_pol_a: assert property (ce |=> txLaneData == (($past(w8_q[`POS_TX_INV]) ? $past(lane_in_neg)
    : $past(lane_in_pos)) & txLaneEnable)) else $error("tx pair polarity wrong");
  rx_pol_a: assert property (ce |=> lane_out_pos == (($past(w8_q[`POS_RX_INV]) ? ~$past(rxLaneData)
    : $past(rxLaneData)) & rxLaneEnable)) else $error("rx pair polarity wrong");
endmodule

bind low_speed_serdes_lane_control_regs lane_ctrl_monitor #(.LANES(LANES)) mon (.clk, .nrst, .ce, .regAddr, .regWrite,
  .regRead, .regWrData, .regRdData, .regRdValid, .channel_powerdown_pin_n, .globalPowerdown, .laneMode,
  .lane_in_pos, .lane_in_neg, .rxLaneData, .txLaneEnable, .rxLaneEnable, .tx_lane_rate_sel, .rx_lane_rate_sel,
  .output_deemphasis_sel, .input_equalizer_sel, .output_swing_sel, .txLaneData, .lane_out_pos, .lane_out_neg);

// >>> tb_top.sv
`timescale 1ns/1ns
`include "lane_ctrl_regs.svh"
// ==========
// Register sequence bench
module tb_top;
  logic                      clk, nrst, ce, regWrite, regRead, regRdValid, channel_powerdown_pin_n, globalPowerdown;
  logic [15:0]               regAddr, regWrData, regRdData, v7, v8;
  logic [3:0]                lane_in_pos, lane_in_neg, rxLaneData, txLaneEnable, rxLaneEnable, txLaneData, m;
  logic [3:0]                lane_out_pos, lane_out_neg, output_deemphasis_sel, input_equalizer_sel;
  logic [2:0]                output_swing_sel;
  lane_ctrl_pkg::lane_mode_t laneMode;
  lane_ctrl_pkg::lane_rate_t tx_lane_rate_sel, rx_lane_rate_sel;
  int                        badCount, samplesChecked, cycles;

  low_speed_serdes_lane_control_regs DUT (.clk, .nrst, .ce, .regAddr, .regWrite, .regRead, .regWrData, .regRdData,
    .regRdValid, .channel_powerdown_pin_n, .globalPowerdown, .laneMode, .lane_in_pos, .lane_in_neg, .rxLaneData,
    .txLaneEnable, .rxLaneEnable, .tx_lane_rate_sel, .rx_lane_rate_sel, .output_deemphasis_sel, .input_equalizer_sel,
    .output_swing_sel, .txLaneData, .lane_out_pos, .lane_out_neg);

  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      badCount++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Lets the edge's updates land before sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk);
    regRead <= 1'h0;
    #1;
    chk("rdValid", 16'h0001, {15'h0000, regRdValid});
    chk("rdData", e, regRdData);
  endtask

  task automatic fields(input logic [15:0] v);
    chk("fields", {5'h00, v[14:12], v[9:8], v[7:4], v[1:0]},
        {5'h00, output_swing_sel, tx_lane_rate_sel, output_deemphasis_sel, rx_lane_rate_sel});
  endtask

  task automatic giveVerdict;
    if (badCount == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, far above the roughly 190 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      badCount++;
      giveVerdict;
    end
  end

  // ==========
  // Main sequence
  initial
  begin
    {nrst, regWrite, regRead, globalPowerdown, regAddr, regWrData} = '0;
    {ce, channel_powerdown_pin_n} = 2'h3;
    laneMode = lane_ctrl_pkg::MODE_FOUR_LANE;
    {lane_in_pos, lane_in_neg, rxLaneData} = 12'hA56;
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    step(2);
    rd(`ADDR_ENABLE_RATE, `RST_ENABLE_RATE);
    rd(`ADDR_POL_EQ, `RST_POL_EQ);
    chk("enables", 16'h00FF, {8'h00, txLaneEnable, rxLaneEnable});
    fields(`RST_ENABLE_RATE);
    chk("pairs", 16'h0A69, {4'h0, txLaneData, lane_out_pos, lane_out_neg});
    wr(`ADDR_POL_EQ, 16'hC000);
    step(1);
    chk("pairs", 16'h0596, {4'h0, txLaneData, lane_out_pos, lane_out_neg});
    for (int i = 0; i < 16; i++)
    begin
      m = i[3:0];
      v7 = {m[3], m[2:0], m[0], 1'h1, m[1:0], m, m[1], 1'h1, ~m[1:0]};
      v8 = {2'h0, m[1:0], m, m, ~m};
      wr(`ADDR_ENABLE_RATE, v7);
      wr(`ADDR_POL_EQ, v8);
      step(1);
      fields(v7);
      chk("eq", {12'h000, m}, {12'h000, input_equalizer_sel});
      rd(`ADDR_ENABLE_RATE, v7);
      rd(`ADDR_POL_EQ, v8);
    end
    wr(`ADDR_ENABLE_RATE, 16'hD800);
    step(1);
    chk("enables", 16'h0000, {8'h00, txLaneEnable, rxLaneEnable});
    wr(`ADDR_ENABLE_RATE, `RST_ENABLE_RATE);
    @(posedge clk);
    channel_powerdown_pin_n <= 1'h0;
    step(1);
    chk("enables", 16'h0000, {8'h00, txLaneEnable, rxLaneEnable});
    @(posedge clk);
    channel_powerdown_pin_n <= 1'h1;
    globalPowerdown <= 1'h1;
    step(1);
    chk("enables", 16'h0000, {8'h00, txLaneEnable, rxLaneEnable});
    @(posedge clk);
    globalPowerdown <= 1'h0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      laneMode <= lane_ctrl_pkg::lane_mode_t'(i[1:0]);
      step(1);
      m = (i == 0) ? 4'hF : (i == 1) ? 4'h3 : 4'h1;
      chk("enables", {8'h00, m, m}, {8'h00, txLaneEnable, rxLaneEnable});
    end
    rd(16'h0009, 16'h0000);
    wr(16'h0009, 16'hFFFF);
    rd(`ADDR_ENABLE_RATE, `RST_ENABLE_RATE);
    // frozen words: a write with the clock enable low is lost
    @(posedge clk);
    ce <= 1'h0;
    wr(`ADDR_POL_EQ, 16'hFFFF);
    @(posedge clk);
    ce <= 1'h1;
    rd(`ADDR_POL_EQ, v8);
    giveVerdict;
  end
endmodule
